/* rtl/thc_pkg.sv */
`default_nettype none
package thc_pkg;
   // Cluster set and code width
   localparam int NUM_CL  = 6;
   localparam int CODE_W  = 10;
   localparam int CL_REG  = 4;  // Regulator cluster index
   localparam int CL_GLB  = 5;  // Global cluster index
   localparam int N_DIG   = 4;  // Clusters judged from ADC only

   // Register byte offsets
   localparam logic [5:0] OFS_GLOBAL = 6'h00;
   localparam logic [5:0] OFS_CLFLAG = 6'h04;
   localparam logic [5:0] OFS_MASK   = 6'h08;
   localparam logic [5:0] OFS_CONFIG = 6'h0C;
   localparam logic [5:0] OFS_WTHR   = 6'h10;
   localparam logic [5:0] OFS_STHR   = 6'h14;
   localparam logic [5:0] OFS_TEMP7  = 6'h18;
   localparam logic [5:0] OFS_TEMP8  = 6'h1C;
   localparam logic [5:0] OFS_TEMP9  = 6'h20;

   // Field positions
   localparam int GLB_WARN_BIT = 0;
   localparam int GLB_SHUT_BIT = 1;
   localparam int GLB_SEC_BIT  = 2;
   localparam int CL_WARN_LSB  = 0;
   localparam int CL_SHUT_LSB  = 8;
   localparam int CFG_MODE_BIT = 0;
   localparam int TEMP_HI_LSB  = 16;

   // Reset values
   localparam logic [31:0]       MASK_RST = 32'h0000_0000;
   localparam logic              MODE_RST = 1'b0;   // Standard mode
   localparam logic [CODE_W-1:0] WTHR_RST = 10'h1C2; // About 130 C
   localparam logic [CODE_W-1:0] STHR_RST = 10'h199; // About 150 C
   localparam logic [CODE_W-1:0] TEMP_RST = 10'h3FF; // Coldest code

   // Filter timing
   localparam int CLK_MHZ        = 100;
   localparam int FILTER_TIME_US = 100;
   localparam int FILTER_CYC     = FILTER_TIME_US * CLK_MHZ;

   // Output to cluster assignment
   localparam int N_OUT = 16;
   localparam logic [2:0] OUT_CL [N_OUT] = '{
      3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2,
      3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
endpackage
`default_nettype wire

/* rtl/thc_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module thc_filter #(
   parameter int CYCLES = 10
) (
   input  wire logic clk,     // System clock
   input  wire logic reset_n, // Sync reset, active low
   input  wire logic cond,    // Over-threshold level
   output logic      hit      // Pulse when time is full
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   localparam logic [CW-1:0] FULL = CW'(CYCLES);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // Restart on any gap, saturate so one pulse per excess
   always_comb
   begin
      if (!cond)
         cnt_d = '0;
      else if (cnt_q == FULL)
         cnt_d = cnt_q;
      else
         cnt_d = cnt_q + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   assign hit = cond && (cnt_q == LAST);

   filter_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
      !cond |=> cnt_q == '0)
      else $error("filter did not restart");
   filter_once_a: assert property (@(posedge clk) disable iff (!reset_n)
      hit |=> !hit)
      else $error("filter hit twice");
endmodule
`default_nettype wire

/* rtl/thc_thermal_protect.sv */
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Global warning flag after warning filter time
// - Filtered shutdown sets flag, outputs off
// - Shutdown discharges gates by resistive low once the global cluster is off
// - Outputs stay off until flags cleared
// - Shutdown needs warning first: two periods
// - Six clusters, each output in one
// - Per-cluster warning, shutdown flag, temperature
// - Code equals (350 - T) / 0.488
// - Temperature codes in status words seven-nine
// - Standard mode: all off, primary regulator kept
// - Cluster mode: only hot cluster off
// - Regulator or global cluster: all off
// - Clusters 1-4 digital, 5-6 comparator shutdown
// - Digital warning and shutdown by code compare
// - Clear-by-one clears only flagged bits
module thc_thermal_protect #(
   parameter int FILTER_CYCLES = thc_pkg::FILTER_CYC,
   parameter int N_OUT         = thc_pkg::N_OUT
) (
   input  wire logic                      clk,             // 100 MHz
   input  wire logic                      reset_n,         // Sync, low
   input  wire logic [3:0]                avs_address,     // Word addr
   input  wire logic                      avs_read,        // Read req
   input  wire logic                      avs_write,       // Write req
   input  wire logic [31:0]               avs_writedata,   // Write data
   input  wire logic [3:0]                avs_byteenable,  // Lanes
   output logic [31:0]                    avs_readdata,    // Read data
   output logic                           avs_waitrequest, // Stall
   input  wire logic                      adc_valid,       // Code strobe
   input  wire logic [2:0]                adc_channel,     // Cluster 0-5
   input  wire logic [thc_pkg::CODE_W-1:0] adc_code,       // Temp code
   input  wire logic [1:0]                cmp_shut_async,  // Cl 5,6 cmp
   input  wire logic                      cmp_second_async, // Cl 5 lvl 2
   output logic [N_OUT-1:0]               out_off,         // Stage off
   output logic                           primary_regulator_off, // Off
   output logic                           gate_resistive_low, // Gates RL
   output logic                           irq              // Level irq
);
   import thc_pkg::*;

   // Byte lanes to bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // Smaller code is hotter, so compare inverted
   function automatic logic hotter(input logic [CODE_W-1:0] code,
                                   input logic [CODE_W-1:0] thr);
      hotter = (code <= thr);
   endfunction

   logic [2:0]        cmp_meta_q;
   logic [2:0]        cmp_sync_q;
   logic [CODE_W-1:0] temp_q [NUM_CL];
   logic [CODE_W-1:0] temp_d [NUM_CL];
   logic [NUM_CL-1:0] warn_q, warn_d, shut_q, shut_d;
   logic [2:0]        glb_q, glb_d;
   logic [31:0]       mask_q, mask_d;
   logic              mode_q, mode_d;
   logic [CODE_W-1:0] wthr_q, wthr_d, sthr_q, sthr_d;
   logic              ack_q, ack_d;
   logic [31:0]       rdata_q, rdata_d;
   logic [NUM_CL-1:0] off_q, off_d;
   logic [NUM_CL-1:0] over_warn, over_shut, warn_hit, shut_hit;
   logic              sec_hit;
   logic [5:0]        byte_addr;
   logic              wr_take;
   logic [31:0]       wmask;
   logic [31:0]       cl_word;

   // Comparators come from the analog side; two flops first
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         cmp_meta_q <= 3'h0;
         cmp_sync_q <= 3'h0;
      end
      else
      begin
         cmp_meta_q <= {cmp_second_async, cmp_shut_async};
         cmp_sync_q <= cmp_meta_q;
      end
   end

   // Latest code per cluster from the ADC sequencer
   always_comb
   begin
      for (int i = 0; i < NUM_CL; i++)
         temp_d[i] = temp_q[i];
      if (adc_valid && (adc_channel < 3'(NUM_CL)))
         temp_d[adc_channel] = adc_code;
   end

   always_ff @(posedge clk)
   begin
      for (int i = 0; i < NUM_CL; i++)
      begin
         if (!reset_n)
            temp_q[i] <= TEMP_RST;
         else
            temp_q[i] <= temp_d[i];
      end
   end

   // Per-cluster judgement and filters
   genvar g;
   generate
      for (g = 0; g < NUM_CL; g++)
      begin : gen_cl
         // Warning is digital for every cluster
         assign over_warn[g] = hotter(temp_q[g], wthr_q);
         if (g < N_DIG)
         begin : gen_dig
            assign over_shut[g] = hotter(temp_q[g], sthr_q);
         end
         else
         begin : gen_ana
            // Comparator path keeps working with the ADC off
            assign over_shut[g] = cmp_sync_q[g - N_DIG];
         end
         // Idle while flagged, so a clear re-arms a fresh count
         thc_filter #(.CYCLES(FILTER_CYCLES)) u_warn (
            .clk     (clk),
            .reset_n (reset_n),
            .cond    (over_warn[g] && !warn_q[g]),
            .hit     (warn_hit[g])
         );
         // Shutdown filter only runs once warning is flagged
         thc_filter #(.CYCLES(FILTER_CYCLES)) u_shut (
            .clk     (clk),
            .reset_n (reset_n),
            .cond    (over_shut[g] && warn_q[g] && !shut_q[g]),
            .hit     (shut_hit[g])
         );
      end
   endgenerate

   // Second shutdown level of the regulator cluster
   thc_filter #(.CYCLES(FILTER_CYCLES)) u_second (
      .clk     (clk),
      .reset_n (reset_n),
      .cond    (cmp_sync_q[2] && !glb_q[GLB_SEC_BIT]),
      .hit     (sec_hit)
   );

   // Bus decode helpers; write lands on the accepting edge
   assign byte_addr = {avs_address, 2'b00};
   assign wr_take   = avs_write && ack_q;
   assign wmask     = lane_mask(avs_byteenable) & {32{wr_take}};
   assign cl_word   = {18'h0, shut_q, 2'b00, warn_q};

   // Flag and configuration next state; set wins over clear
   always_comb
   begin
      logic [31:0] clr;
      clr    = 32'h0;
      warn_d = warn_q;
      shut_d = shut_q;
      glb_d  = glb_q;
      mask_d = mask_q;
      mode_d = mode_q;
      wthr_d = wthr_q;
      sthr_d = sthr_q;
      if (byte_addr == OFS_GLOBAL)
      begin
         clr   = avs_writedata & wmask;
         glb_d = glb_q & ~clr[2:0];
      end
      else if (byte_addr == OFS_CLFLAG)
      begin
         clr    = avs_writedata & wmask;
         warn_d = warn_q & ~clr[CL_WARN_LSB +: NUM_CL];
         shut_d = shut_q & ~clr[CL_SHUT_LSB +: NUM_CL];
      end
      else if (byte_addr == OFS_MASK)
         mask_d = (mask_q & ~wmask) | (avs_writedata & wmask);
      else if (byte_addr == OFS_CONFIG)
      begin
         if (wmask[CFG_MODE_BIT])
            mode_d = avs_writedata[CFG_MODE_BIT];
      end
      else if (byte_addr == OFS_WTHR)
         wthr_d = (wthr_q & ~wmask[CODE_W-1:0])
                | (avs_writedata[CODE_W-1:0] & wmask[CODE_W-1:0]);
      else if (byte_addr == OFS_STHR)
         sthr_d = (sthr_q & ~wmask[CODE_W-1:0])
                | (avs_writedata[CODE_W-1:0] & wmask[CODE_W-1:0]);
      warn_d = warn_d | warn_hit;
      shut_d = shut_d | shut_hit;
      if (|warn_hit)
         glb_d[GLB_WARN_BIT] = 1'b1;
      if (|shut_hit)
         glb_d[GLB_SHUT_BIT] = 1'b1;
      if (sec_hit)
         glb_d[GLB_SEC_BIT] = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         warn_q <= '0;
         shut_q <= '0;
         glb_q  <= 3'h0;
         mask_q <= MASK_RST;
         mode_q <= MODE_RST;
         wthr_q <= WTHR_RST;
         sthr_q <= STHR_RST;
      end
      else
      begin
         warn_q <= warn_d;
         shut_q <= shut_d;
         glb_q  <= glb_d;
         mask_q <= mask_d;
         mode_q <= mode_d;
         wthr_q <= wthr_d;
         sthr_q <= sthr_d;
      end
   end

   // One wait cycle; read data prepared while stalled
   always_comb
   begin
      ack_d   = (avs_read || avs_write) && !ack_q;
      rdata_d = rdata_q;
      if (avs_read && !ack_q)
      begin
         if (byte_addr == OFS_GLOBAL)
            rdata_d = {29'h0, glb_q};
         else if (byte_addr == OFS_CLFLAG)
            rdata_d = cl_word;
         else if (byte_addr == OFS_MASK)
            rdata_d = mask_q;
         else if (byte_addr == OFS_CONFIG)
            rdata_d = {31'h0, mode_q};
         else if (byte_addr == OFS_WTHR)
            rdata_d = {22'h0, wthr_q};
         else if (byte_addr == OFS_STHR)
            rdata_d = {22'h0, sthr_q};
         else if (byte_addr == OFS_TEMP7)
            rdata_d = {6'h0, temp_q[1], 6'h0, temp_q[0]};
         else if (byte_addr == OFS_TEMP8)
            rdata_d = {6'h0, temp_q[3], 6'h0, temp_q[2]};
         else if (byte_addr == OFS_TEMP9)
            rdata_d = {6'h0, temp_q[5], 6'h0, temp_q[4]};
         else
            rdata_d = 32'h0; // Unmapped reads zero
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
      end
      else
      begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_waitrequest = !ack_q;
   assign avs_readdata    = rdata_q;

   // Switch-off state per cluster; held until flags clear
   always_comb
   begin
      logic trig_all;
      logic busy_std;
      logic busy_ana;
      trig_all = mode_q ? (shut_q[CL_REG] || shut_q[CL_GLB])
                        : (|shut_q);
      busy_std = (|warn_q) || (|shut_q)
               || glb_q[GLB_WARN_BIT] || glb_q[GLB_SHUT_BIT];
      busy_ana = warn_q[CL_REG] || shut_q[CL_REG]
               || warn_q[CL_GLB] || shut_q[CL_GLB];
      for (int i = 0; i < NUM_CL; i++)
      begin
         if (trig_all || (mode_q && shut_q[i]))
            off_d[i] = 1'b1;
         else if (mode_q)
            off_d[i] = off_q[i] && (warn_q[i] || shut_q[i] || busy_ana);
         else
            off_d[i] = off_q[i] && busy_std;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         off_q <= '0;
      else
         off_q <= off_d;
   end

   // Each stage follows exactly one cluster
   generate
      for (g = 0; g < N_OUT; g++)
      begin : gen_out
         assign out_off[g] = off_q[OUT_CL[g]];
      end
   endgenerate

   // Primary regulator survives until the second level
   assign primary_regulator_off = glb_q[GLB_SEC_BIT];
   // Resistive low instead of active low while shut down with the global cluster off
   assign gate_resistive_low = glb_q[GLB_SHUT_BIT] && off_q[CL_GLB];
   assign irq = |(cl_word & mask_q);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   warn_after_filter_a: assert property (
      $rose(glb_q[GLB_WARN_BIT]) |-> $past(|warn_hit))
      else $error("warning flag without filter hit");
   shut_all_off_a: assert property (
      (|shut_hit && !mode_q) |=> ##1 (&off_q))
      else $error("standard shutdown left a cluster on");
   resistive_low_a: assert property (
      $rose(glb_q[GLB_SHUT_BIT]) && !mode_q |=> ##1 gate_resistive_low)
      else $error("gates not resistive low on shutdown");
   hold_off_a: assert property (
      (off_q[0] && !mode_q && $stable(mode_q) && (|warn_q || |shut_q))
      |=> off_q[0])
      else $error("outputs back on with flags set");
   warn_before_shut_a: assert property (
      $rose(shut_q[0]) |-> $past(warn_q[0], 2))
      else $error("shutdown without prior warning");
   cluster_only_a: assert property (
      (mode_q && !off_q[1] && !shut_q[1] && !shut_q[CL_REG]
       && !shut_q[CL_GLB]) |=> !off_q[1])
      else $error("cluster mode switched off a cool cluster");
   global_all_off_a: assert property (
      $rose(shut_q[CL_GLB]) |=> (&off_q))
      else $error("global cluster shutdown left outputs on");
   primary_kept_a: assert property (
      $rose(primary_regulator_off) |-> $past(sec_hit))
      else $error("primary regulator switched off too early");
   code_order_a: assert property (
      (temp_q[2] > sthr_q) |-> !over_shut[2])
      else $error("cold code judged hot");
   irq_level_a: assert property (
      irq == ((|(warn_q & mask_q[CL_WARN_LSB +: NUM_CL]))
              || (|(shut_q & mask_q[CL_SHUT_LSB +: NUM_CL]))))
      else $error("interrupt does not follow masked flags");
endmodule
`default_nettype wire

/* sim/thc_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the cluster sensors, the shared converter and comparators
module thc_sensor_model (
   input  wire logic            clk,             // System clock
   input  wire logic            reset_n,         // Sync reset, low
   input  wire logic [5:0][9:0] code_set,        // Code per cluster
   input  wire logic [1:0]      shut_set,        // Comparator levels
   input  wire logic            second_set,      // Second level
   output logic                 adc_valid,       // Code strobe
   output logic [2:0]           adc_channel,     // Channel number
   output logic [9:0]           adc_code,        // Converted code
   output logic [1:0]           cmp_shut_async,  // Cl 5,6 shutdown
   output logic                 cmp_second_async // Cl 5 second level
);
   logic       slot_q = 1'b0;
   logic [2:0] ch_q   = 3'h0;

   // Scan all eight channels, one every other cycle; channels 6 and 7
   // carry the hottest code so that bad channel decoding shows up
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         slot_q    <= 1'b0;
         ch_q        <= 3'h0;
         adc_valid   <= 1'b0;
         adc_channel <= 3'h0;
         adc_code    <= 10'h000;
      end
      else
      begin
         slot_q    <= ~slot_q;
         adc_valid <= slot_q;
         if (slot_q)
         begin
            adc_channel <= ch_q;
            adc_code    <= (ch_q < 3'h6) ? code_set[ch_q] : 10'h000;
            ch_q        <= ch_q + 3'h1;
         end
         else
         begin
            adc_code <= ~adc_code; // Code is not held outside the strobe
         end
      end
   end

   // Comparators are analog, so they also work while the converter sleeps
   assign cmp_shut_async   = shut_set;
   assign cmp_second_async = second_set;
endmodule
`default_nettype wire

/* sim/thc_thermal_protect_test.sv */
`timescale 1ns/1ps
`default_nettype none
module thc_thermal_protect_test;
   import thc_pkg::*;
   localparam int F = 8;
   localparam logic [5:0][9:0] COOL = {10'h2D0, 10'h2C0, 10'h2B0,
                                       10'h2A0, 10'h31F, 10'h29A};
   logic                  clk             = 1'b0;
   logic                  reset_n         = 1'b0;
   logic [3:0]            avs_address     = 4'h0;
   logic                  avs_read        = 1'b0;
   logic                  avs_write       = 1'b0;
   logic [31:0]           avs_writedata   = 32'h0;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   logic                  adc_valid;
   logic [2:0]            adc_channel;
   logic [CODE_W-1:0]     adc_code;
   logic [1:0]            cmp_shut_async;
   logic                  cmp_second_async;
   logic [15:0]           out_off;
   logic                  prim_off;
   logic                  gate_rl;
   logic                  irq;
   logic [5:0][9:0]       code_set        = COOL;
   logic [1:0]            shut_set        = 2'h0;
   logic                  second_set      = 1'b0;
   logic [31:0]           rdata;
   int                    n_fail          = 0;
   int                    n_compared      = 0;

   always #5 clk = ~clk;

   thc_thermal_protect #(.FILTER_CYCLES(F)) u_thc_thermal_protect (
      .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .adc_valid(adc_valid), .adc_channel(adc_channel),
      .adc_code(adc_code), .cmp_shut_async(cmp_shut_async),
      .cmp_second_async(cmp_second_async), .out_off(out_off),
      .primary_regulator_off(prim_off), .gate_resistive_low(gate_rl),
      .irq(irq));

   thc_sensor_model u_thc_sensor_model (
      .clk(clk), .reset_n(reset_n), .code_set(code_set),
      .shut_set(shut_set), .second_set(second_set),
      .adc_valid(adc_valid), .adc_channel(adc_channel),
      .adc_code(adc_code), .cmp_shut_async(cmp_shut_async),
      .cmp_second_async(cmp_second_async));

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Hold the request until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [5:0] ofs,
                      input logic [31:0] d);
      @(posedge clk);
      avs_address   <= ofs[5:2];
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rc(input logic [5:0] ofs, input logic [31:0] exp,
                     input string name);
      bus(1'b0, ofs, 32'h0);
      chk(name, exp, rdata);
   endtask

   // Output stages, then irq, gate drive and regulator in that order
   task automatic pins(input logic [15:0] off, input logic [2:0] igp);
      chk("out_off", {16'h0, off}, {16'h0, out_off});
      chk("irq_gate_reg", {29'h0, igp}, {29'h0, irq, gate_rl, prim_off});
   endtask

   // Cool down first, else set would win over the clear
   task automatic clear_all;
      code_set   <= COOL;
      shut_set   <= 2'h0;
      second_set <= 1'b0;
      cyc(40);
      bus(1'b1, OFS_CLFLAG, 32'h3F3F);
      bus(1'b1, OFS_GLOBAL, 32'h7);
      cyc(3);
      rc(OFS_CLFLAG, 32'h0, "clflag_clr");
      pins(16'h0, 3'b000);
   endtask

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      #50000;
      n_fail++;
      end_sim();
   end

   initial
   begin
      cyc(3);
      reset_n <= 1'b1;
      // Reset values and an unmapped word
      rc(OFS_GLOBAL, 32'h0, "global_rst");
      rc(OFS_CLFLAG, 32'h0, "clflag_rst");
      rc(OFS_MASK, MASK_RST, "mask_rst");
      rc(OFS_CONFIG, {31'h0, MODE_RST}, "config_rst");
      rc(OFS_WTHR, {22'h0, WTHR_RST}, "wthr_rst");
      rc(OFS_STHR, {22'h0, STHR_RST}, "sthr_rst");
      rc(6'h3C, 32'h0, "unmapped");
      pins(16'h0, 3'b000);
      // Cluster codes in the three temperature words
      cyc(20);
      rc(OFS_TEMP7, 32'h031F_029A, "temp7");
      rc(OFS_TEMP8, 32'h02B0_02A0, "temp8");
      rc(OFS_TEMP9, 32'h02D0_02C0, "temp9");
      // Warning only, then interrupt masking
      code_set[0] <= 10'h1B0;
      cyc(60);
      rc(OFS_GLOBAL, 32'h1, "global_warn");
      rc(OFS_CLFLAG, 32'h1, "clflag_warn");
      pins(16'h0, 3'b000);
      bus(1'b1, OFS_MASK, 32'h100);
      cyc(2);
      pins(16'h0, 3'b000);
      bus(1'b1, OFS_MASK, 32'h1);
      cyc(2);
      pins(16'h0, 3'b100);
      clear_all();
      // Standard mode shutdown of cluster one
      code_set[0] <= 10'h100;
      cyc(2 * F - 1);
      pins(16'h0, 3'b000);
      cyc(60);
      rc(OFS_GLOBAL, 32'h3, "global_shut");
      rc(OFS_CLFLAG, 32'h101, "clflag_shut");
      pins(16'hFFFF, 3'b110);
      // Clear while still hot: back on, then off again after two periods
      bus(1'b1, OFS_CLFLAG, 32'h101);
      bus(1'b1, OFS_GLOBAL, 32'h3);
      cyc(2);
      chk("out_off_clr", 32'h0, {16'h0, out_off});
      cyc(2 * F - 8);
      chk("out_off_min", 32'h0, {16'h0, out_off});
      cyc(60);
      chk("out_off_again", 32'hFFFF, {16'h0, out_off});
      // Payload of ones clears only those bits
      code_set[0] <= COOL[0];
      cyc(40);
      bus(1'b1, OFS_CLFLAG, 32'h100);
      rc(OFS_CLFLAG, 32'h1, "clflag_part");
      chk("out_off_held", 32'hFFFF, {16'h0, out_off});
      clear_all();
      // Cluster mode: only cluster two goes off
      bus(1'b1, OFS_CONFIG, 32'h1);
      code_set[1] <= 10'h100;
      cyc(60);
      rc(OFS_CLFLAG, 32'h202, "clflag_cl2");
      pins(16'h0038, 3'b000);
      clear_all();
      // Global cluster: code alone gives warning, comparator gives shutdown
      code_set[5] <= 10'h100;
      cyc(60);
      rc(OFS_CLFLAG, 32'h20, "clflag_cl6_warn");
      repeat (6)
      begin
         shut_set <= 2'h2;
         cyc(4);
         shut_set <= 2'h0;
         cyc(4);
      end
      rc(OFS_CLFLAG, 32'h20, "clflag_pulses");
      shut_set <= 2'h2;
      cyc(30);
      rc(OFS_CLFLAG, 32'h2020, "clflag_cl6_shut");
      pins(16'hFFFF, 3'b010);
      second_set <= 1'b1;
      cyc(10);
      rc(OFS_GLOBAL, 32'h7, "global_second");
      pins(16'hFFFF, 3'b011);
      clear_all();
      // Threshold words keep only the code bits
      bus(1'b1, OFS_WTHR, 32'hFFFF_F155);
      rc(OFS_WTHR, 32'h155, "wthr_wr");
      bus(1'b1, OFS_STHR, 32'hFFFF_F0AA);
      rc(OFS_STHR, 32'h0AA, "sthr_wr");
      end_sim();
   end
endmodule
`default_nettype wire
